// ===== hw/bfc_defines.svh
/*
  Shared constants of the bidirectional queue port block.
  Assumes it is included by bare name before any file that uses it.
*/
// Contract
// - Port A almost-empty low when B-to-A count at threshold.
// - Port B almost-empty low when A-to-B count at threshold.
// - Port A almost-full low when A-to-B free at threshold.
// - Port B almost-full low when B-to-A free at threshold.
// - Both ports carry 36-bit two-way data buses.
// - Select high at reset gives big-endian piece order.
// - Select low at reset gives little-endian piece order.
// - After reset select high standard, low fall-through.
// - Match low gives long word, high byte/word per size.
// - Port A clock free-running; port A work on rising edge.
// - Fall-through shows first word without read request.
// - Full and almost-full synchronised by two writer-clock stages.
`ifndef BFC_DEFINES_SVH
`define BFC_DEFINES_SVH
`define BFC_DATA_W 36
`define BFC_DEPTH 8
`define BFC_HALF_W 18
`define BFC_BYTE_W 9
`define BFC_LAST_LONG 2'h0
`define BFC_LAST_HALF 2'h1
`define BFC_LAST_BYTE 2'h3
`define BFC_IDX_FIRST 2'h0
`define BFC_IDX_STEP 2'h1
`define BFC_CAPTURE_WAIT 2'h2
`define BFC_CNT_W 4
`endif

// ===== hw/bfc_pkg.sv
/*
  Types of the bidirectional queue port block.
  Assumes bfc_defines.svh is available on the include path.
*/
`include "bfc_defines.svh"
package bfc_pkg;
  typedef logic [`BFC_DATA_W-1:0] bfc_word_t;
  typedef enum {BFC_LONG, BFC_HALF, BFC_BYTE} bfc_width_e;
endpackage : bfc_pkg

// ===== hw/bfc_fifo_if.sv
/*
  Carrier between the port logic and one dual-clock queue.
  Assumes the write group lives on the writer clock and the read group on the reader clock.
*/
interface bfc_fifo_if #(parameter int W = 36, parameter int CW = 4);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic [CW-1:0] wr_count;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  logic [CW-1:0] rd_count;
  modport store(input wr_valid, input wr_data, input rd_ready, output wr_ready, output wr_count,
                output rd_valid, output rd_data, output rd_count);
  modport user(output wr_valid, output wr_data, output rd_ready, input wr_ready, input wr_count,
               input rd_valid, input rd_data, input rd_count);
endinterface : bfc_fifo_if

// ===== hw/bfc_sync2.sv
/*
  Two-stage level synchroniser of any width.
  Assumes each bit is a quasi-static level or a gray-coded value.
*/
module bfc_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : bfc_sync2

// ===== hw/bfc_fifo.sv
/*
  Dual-clock queue with gray-coded pointers and a fill count on each side.
  Assumes each reset is released synchronously to its own clock.
*/
module bfc_fifo #(
  parameter int W = 36,
  parameter int DEPTH = 8
) (
  input wire logic wr_clk,
  input wire logic wr_rst_n,
  input wire logic rd_clk,
  input wire logic rd_rst_n,
  bfc_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  if (DEPTH < 2 || (1 << AW) != DEPTH || $bits(f.wr_count) != CW || $bits(f.wr_data) != W) begin : g_bad
    $error("bfc_fifo needs a power-of-two depth and matching carrier widths.");
  end

  logic [W-1:0] mem [DEPTH];
  logic [CW-1:0] wbin, rbin, wgray, rgray, wgray_r, rgray_w;

  function automatic logic [CW-1:0] gray_to_bin(input logic [CW-1:0] g);
    logic [CW-1:0] b;
    b[CW-1] = g[CW-1];
    for (int i = CW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray_to_bin

  assign wgray = wbin ^ (wbin >> 1);
  assign rgray = rbin ^ (rbin >> 1);

  // Only gray pointers cross, so a torn sample is off by one step at most.
  bfc_sync2 #(.W(CW)) u_w2r (.clk(rd_clk), .rst_n(rd_rst_n), .d(wgray), .q(wgray_r));
  bfc_sync2 #(.W(CW)) u_r2w (.clk(wr_clk), .rst_n(wr_rst_n), .d(rgray), .q(rgray_w));

  assign f.wr_count = wbin - gray_to_bin(rgray_w);
  assign f.wr_ready = f.wr_count != CW'(DEPTH);
  assign f.rd_count = gray_to_bin(wgray_r) - rbin;
  assign f.rd_valid = f.rd_count != '0;
  assign f.rd_data = mem[rbin[AW-1:0]];

  always_ff @(posedge wr_clk) begin
    if (f.wr_valid && f.wr_ready) begin
      mem[wbin[AW-1:0]] <= f.wr_data;
    end
  end

  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      wbin <= '0;
    end else if (f.wr_valid && f.wr_ready) begin
      wbin <= wbin + CW'(1);
    end
  end

  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      rbin <= '0;
    end else if (f.rd_ready && f.rd_valid) begin
      rbin <= rbin + CW'(1);
    end
  end
endmodule : bfc_fifo

// ===== hw/bfc_port_flags.sv
/*
  Two-port bidirectional queue with almost flags, endian and timing select, and port B bus matching.
  Assumes port A pins are synchronous to clk_sys, port B pins to port_b_clock, and the select,
  bus-match, size and threshold pins are static levels.
  Port B pieces sit in the low bits of its bus, the rest zero.
  Almost flags count queue words only, not a shown fall-through word.
  Depth must be a power of two from 2 to 1024.
*/
`include "bfc_defines.svh"
module bfc_port_flags #(
  parameter int DEPTH = `BFC_DEPTH,
  localparam int CW = $clog2(DEPTH) + 1
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic port_b_clock,
  input wire logic endian_timing_select,
  input wire logic bus_width_match_select,
  input wire logic port_b_size_select,
  input wire logic [CW-1:0] a_side_empty_threshold,
  input wire logic [CW-1:0] a_side_full_threshold,
  input wire logic [CW-1:0] b_side_empty_threshold,
  input wire logic [CW-1:0] b_side_full_threshold,
  input wire logic port_a_transfer_gate,
  input wire logic port_a_write_select,
  input wire logic [`BFC_DATA_W-1:0] port_a_data_bus_in,
  output logic [`BFC_DATA_W-1:0] port_a_data_bus_out,
  output logic port_a_data_bus_oe,
  output logic port_a_input_ready,
  output logic port_a_output_ready,
  output logic port_a_almost_empty_flag_n,
  output logic port_a_almost_full_flag_n,
  input wire logic port_b_transfer_gate,
  input wire logic port_b_write_select,
  input wire logic [`BFC_DATA_W-1:0] port_b_data_bus_in,
  output logic [`BFC_DATA_W-1:0] port_b_data_bus_out,
  output logic port_b_data_bus_oe,
  output logic port_b_input_ready,
  output logic port_b_output_ready,
  output logic port_b_almost_empty_flag_n,
  output logic port_b_almost_full_flag_n
);
  if (DEPTH < 2 || DEPTH > 1024) begin : g_bad
    $error("bfc_port_flags supports queue depths from 2 to 1024.");
  end

  // One queue per direction; counts cross as gray pointers inside each.
  bfc_fifo_if #(.W(`BFC_DATA_W), .CW(CW)) a_to_b_queue ();
  bfc_fifo_if #(.W(`BFC_DATA_W), .CW(CW)) b_to_a_queue ();

  // Port B reset pair.
  logic rst_b_meta;
  logic rst_b_n;

  // Synchronised copies of the static pins.
  logic sel_a;
  logic sel_b;
  logic match_b;
  logic size_b;
  logic big_b;
  logic [CW-1:0] a_empty_thr;
  logic [CW-1:0] a_full_thr;
  logic [CW-1:0] b_empty_thr;
  logic [CW-1:0] b_full_thr;

  // Endian capture and the timing mode of each side.
  logic [1:0] capture_wait;
  logic endian_caught;
  logic big_endian;
  logic fall_through_timing_a;
  logic fall_through_timing_b;

  // Port B logic gets its own reset, asserted at once and released on its own clock.
  always_ff @(posedge port_b_clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_b_meta <= 1'h0;
      rst_b_n <= 1'h0;
    end else begin
      rst_b_meta <= 1'h1;
      rst_b_n <= rst_b_meta;
    end
  end

  // Static pins still pass two stages, since they come from outside both clocks.
  bfc_sync2 #(.W(1 + 2 * CW)) u_cfg_a (
    .clk(clk_sys),
    .rst_n(arst_n),
    .d({endian_timing_select,
        a_side_empty_threshold,
        a_side_full_threshold}),
    .q({sel_a,
        a_empty_thr,
        a_full_thr})
  );

  // Port B copies also carry the caught endian level across.
  bfc_sync2 #(.W(4 + 2 * CW)) u_cfg_b (
    .clk(port_b_clock),
    .rst_n(rst_b_n),
    .d({endian_timing_select,
        bus_width_match_select,
        port_b_size_select,
        big_endian,
        b_side_empty_threshold,
        b_side_full_threshold}),
    .q({sel_b,
        match_b,
        size_b,
        big_b,
        b_empty_thr,
        b_full_thr})
  );

  // The endian level is caught once, as soon as the synchroniser holds a true sample after reset.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      capture_wait <= `BFC_IDX_FIRST;
      endian_caught <= 1'h0;
      big_endian <= 1'h0;
    end else if (!endian_caught) begin
      if (capture_wait == `BFC_CAPTURE_WAIT) begin
        endian_caught <= 1'h1;
        big_endian <= sel_a;
      end else begin
        capture_wait <= capture_wait + `BFC_IDX_STEP;
      end
    end
  end

  // From then on the same pin chooses the timing mode; it must stay put while in use.
  // Port A waits for the capture so the endian level is never taken as a mode.
  assign fall_through_timing_a = endian_caught && !sel_a;
  // Port B may briefly see the endian level as a mode; its queue is empty then.
  assign fall_through_timing_b = !sel_b;

  // Port A writes and port B reads this queue.
  bfc_fifo #(.W(`BFC_DATA_W), .DEPTH(DEPTH)) u_a_to_b (
    .wr_clk(clk_sys),
    .wr_rst_n(arst_n),
    .rd_clk(port_b_clock),
    .rd_rst_n(rst_b_n),
    .f(a_to_b_queue.store)
  );

  // Port B writes and port A reads this queue.
  bfc_fifo #(.W(`BFC_DATA_W), .DEPTH(DEPTH)) u_b_to_a (
    .wr_clk(port_b_clock),
    .wr_rst_n(rst_b_n),
    .rd_clk(clk_sys),
    .rd_rst_n(arst_n),
    .f(b_to_a_queue.store)
  );

  // Port A side, all on the rising edge of clk_sys.
  logic a_rd_req;
  logic a_valid;
  logic a_pop;

  // A read is any gated edge with the write select low.
  assign a_rd_req = port_a_transfer_gate && !port_a_write_select;
  assign a_to_b_queue.wr_valid = port_a_transfer_gate && port_a_write_select;
  assign a_to_b_queue.wr_data = port_a_data_bus_in;
  assign port_a_input_ready = a_to_b_queue.wr_ready;
  assign port_a_data_bus_oe = !port_a_write_select;

  // Fall-through keeps one word on the bus and refills it once it is read.
  always_comb begin
    if (fall_through_timing_a) begin
      a_pop = b_to_a_queue.rd_valid && (!a_valid || a_rd_req);
    end else begin
      a_pop = b_to_a_queue.rd_valid && a_rd_req;
    end
  end
  assign b_to_a_queue.rd_ready = a_pop;
  assign port_a_output_ready = fall_through_timing_a ? a_valid : b_to_a_queue.rd_valid;

  // Read data is registered, so it changes only at a popping edge.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      port_a_data_bus_out <= '0;
    end else if (a_pop) begin
      port_a_data_bus_out <= b_to_a_queue.rd_data;
    end
  end

  // The shown-word flag only lives in fall-through mode.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      a_valid <= 1'h0;
    end else if (!fall_through_timing_a) begin
      a_valid <= 1'h0;
    end else if (a_pop) begin
      a_valid <= 1'h1;
    end else if (a_rd_req) begin
      a_valid <= 1'h0;
    end
  end

  // Free places in each queue as its writer sees them.
  logic [CW-1:0] a_free;
  logic [CW-1:0] b_free;
  assign a_free = CW'(DEPTH) - a_to_b_queue.wr_count;
  assign b_free = CW'(DEPTH) - b_to_a_queue.wr_count;

  // Only the far pointer comes through two clk_sys stages; each flag follows its own port's transfers one edge later.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      port_a_almost_empty_flag_n <= 1'h0;
      port_a_almost_full_flag_n <= 1'h1;
    end else begin
      port_a_almost_empty_flag_n <= !(b_to_a_queue.rd_count <= a_empty_thr);
      port_a_almost_full_flag_n <= !(a_free <= a_full_thr);
    end
  end

  // Port B side, all on the rising edge of port_b_clock.
  bfc_pkg::bfc_width_e width_b;
  // Port B width decode and read and write state.
  logic [1:0] last_b;
  logic b_rd_req;
  logic b_wr;
  logic b_valid;
  logic b_step;
  logic b_want;
  logic b_pop;
  logic [1:0] b_idx;
  logic [1:0] b_widx;
  bfc_pkg::bfc_word_t b_word;
  bfc_pkg::bfc_word_t b_acc;

  // Port B width follows the bus-match and size pins.
  always_comb begin
    if (!match_b) begin
      width_b = bfc_pkg::BFC_LONG;
    end else if (size_b) begin
      width_b = bfc_pkg::BFC_BYTE;
    end else begin
      width_b = bfc_pkg::BFC_HALF;
    end
  end

  // Index of the last piece of a long word.
  always_comb begin
    unique case (width_b)
      bfc_pkg::BFC_LONG: last_b = `BFC_LAST_LONG;
      bfc_pkg::BFC_HALF: last_b = `BFC_LAST_HALF;
      bfc_pkg::BFC_BYTE: last_b = `BFC_LAST_BYTE;
    endcase
  end

  // Lane of the long word that a piece index stands for; big-endian walks from the top.
  function automatic logic [1:0] lane_of(input logic [1:0] idx, input logic [1:0] last, input logic big);
    return big ? last - idx : idx;
  endfunction : lane_of

  // One lane of a word, right-aligned with the rest zero.
  function automatic bfc_pkg::bfc_word_t piece_of(input bfc_pkg::bfc_word_t word, input logic [1:0] lane,
                                                  input bfc_pkg::bfc_width_e width);
    bfc_pkg::bfc_word_t p;
    p = '0;
    unique case (width)
      bfc_pkg::BFC_LONG: p = word;
      bfc_pkg::BFC_HALF: p[`BFC_HALF_W-1:0] = word[lane[0]*`BFC_HALF_W +: `BFC_HALF_W];
      bfc_pkg::BFC_BYTE: p[`BFC_BYTE_W-1:0] = word[lane*`BFC_BYTE_W +: `BFC_BYTE_W];
    endcase
    return p;
  endfunction : piece_of

  // A word with one lane replaced by the written piece.
  function automatic bfc_pkg::bfc_word_t put_piece(input bfc_pkg::bfc_word_t acc, input bfc_pkg::bfc_word_t din,
                                                   input logic [1:0] lane, input bfc_pkg::bfc_width_e width);
    bfc_pkg::bfc_word_t r;
    r = acc;
    unique case (width)
      bfc_pkg::BFC_LONG: r = din;
      bfc_pkg::BFC_HALF: r[lane[0]*`BFC_HALF_W +: `BFC_HALF_W] = din[`BFC_HALF_W-1:0];
      bfc_pkg::BFC_BYTE: r[lane*`BFC_BYTE_W +: `BFC_BYTE_W] = din[`BFC_BYTE_W-1:0];
    endcase
    return r;
  endfunction : put_piece

  // The bus drives out whenever the host is not writing.
  assign b_rd_req = port_b_transfer_gate && !port_b_write_select;
  assign port_b_data_bus_oe = !port_b_write_select;

  // A read walks the pieces of the held word and fetches a new one only after the last piece.
  assign b_step = b_valid && (b_idx != last_b);
  assign b_want = fall_through_timing_b ? (!b_valid || (b_rd_req && !b_step))
                         : (b_rd_req && !b_step);
  assign b_pop = b_want && a_to_b_queue.rd_valid;
  assign a_to_b_queue.rd_ready = b_pop;
  assign port_b_output_ready = fall_through_timing_b ? b_valid : (a_to_b_queue.rd_valid || b_step);

  always_ff @(posedge port_b_clock or negedge rst_b_n) begin
    if (!rst_b_n) begin
      b_valid <= 1'h0;
      b_idx <= `BFC_IDX_FIRST;
      b_word <= '0;
      port_b_data_bus_out <= '0;
    end else if (b_rd_req && b_step) begin
      b_idx <= b_idx + `BFC_IDX_STEP;
      port_b_data_bus_out <= piece_of(b_word, lane_of(b_idx + `BFC_IDX_STEP, last_b, big_b),
                                      width_b);
    end else if (b_pop) begin
      b_valid <= 1'h1;
      b_idx <= `BFC_IDX_FIRST;
      b_word <= a_to_b_queue.rd_data;
      port_b_data_bus_out <= piece_of(a_to_b_queue.rd_data, lane_of(`BFC_IDX_FIRST, last_b, big_b),
                                      width_b);
    end else if (b_rd_req) begin
      b_valid <= 1'h0;
    end
  end

  // Pieces are refused while the queue is full, so no partial word is ever lost at a push.
  assign b_wr = port_b_transfer_gate && port_b_write_select && b_to_a_queue.wr_ready;
  assign b_to_a_queue.wr_valid = b_wr && (b_widx == last_b);
  assign b_to_a_queue.wr_data = put_piece(b_acc, port_b_data_bus_in, lane_of(b_widx, last_b, big_b), width_b);
  assign port_b_input_ready = b_to_a_queue.wr_ready;

  // The write index counts pieces of the word being assembled.
  always_ff @(posedge port_b_clock or negedge rst_b_n) begin
    if (!rst_b_n) begin
      b_widx <= `BFC_IDX_FIRST;
      b_acc <= '0;
    end else if (b_wr) begin
      b_acc <= b_to_a_queue.wr_data;
      b_widx <= (b_widx == last_b) ? `BFC_IDX_FIRST : b_widx + `BFC_IDX_STEP;
    end
  end

  // Port B flags compare in its own clock, like those of port A.
  always_ff @(posedge port_b_clock or negedge rst_b_n) begin
    if (!rst_b_n) begin
      port_b_almost_empty_flag_n <= 1'h0;
      port_b_almost_full_flag_n <= 1'h1;
    end else begin
      port_b_almost_empty_flag_n <= !(a_to_b_queue.rd_count <= b_empty_thr);
      port_b_almost_full_flag_n <= !(b_free <= b_full_thr);
    end
  end
endmodule : bfc_port_flags

// ===== sim/bfc_port_flags_sva.sv
/*
  Checker of the flag and bus behaviour of the queue block.
  Assumes it is bound to bfc_port_flags and sees its ports only.
*/
`include "bfc_defines.svh"
module bfc_port_flags_sva (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic port_b_clock,
  input wire logic endian_timing_select,
  input wire logic bus_width_match_select,
  input wire logic port_b_size_select,
  input wire logic port_a_transfer_gate,
  input wire logic port_a_write_select,
  input wire logic port_a_data_bus_oe,
  input wire logic port_a_input_ready,
  input wire logic port_a_output_ready,
  input wire logic port_a_almost_empty_flag_n,
  input wire logic port_a_almost_full_flag_n,
  input wire logic port_b_transfer_gate,
  input wire logic port_b_write_select,
  input wire logic [`BFC_DATA_W-1:0] port_b_data_bus_out,
  input wire logic port_b_input_ready,
  input wire logic port_b_output_ready,
  input wire logic port_b_almost_empty_flag_n,
  input wire logic port_b_almost_full_flag_n
);
  logic [2:0] a_wr_age;
  wire a_rd = port_a_transfer_gate && !port_a_write_select;
  wire b_wr = port_b_transfer_gate && port_b_write_select;
  // The age saturates so a long idle spell never looks like a recent write.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) a_wr_age <= 3'h7;
    else if (port_a_transfer_gate && port_a_write_select) a_wr_age <= 3'h0;
    else if (a_wr_age != 3'h7) a_wr_age <= a_wr_age + 3'h1;
  end
  sequence s_a_full_low;
    ##[0:2] !port_a_almost_full_flag_n;
  endsequence
  sequence s_b_full_low;
    ##[0:2] !port_b_almost_full_flag_n;
  endsequence
  a_oe_port_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    port_a_data_bus_oe == !port_a_write_select) else $error("port A drive enable wrong");
  a_full_low_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $fell(port_a_input_ready) |-> s_a_full_low) else $error("port A full without almost full");
  a_empty_low_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $fell(port_a_output_ready) |-> ##[0:3] !port_a_almost_empty_flag_n) else $error("port A empty flag high");
  a_full_cause_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $fell(port_a_almost_full_flag_n) |-> a_wr_age <= 3'h5) else $error("port A almost full fell unwritten");
  a_empty_cause_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $fell(port_a_almost_empty_flag_n) && endian_timing_select |->
    $past(a_rd, 1) || $past(a_rd, 2) || $past(a_rd, 3) || $past(a_rd, 4)) else $error("port A empty fell unread");
  a_full_low_b: assert property (@(posedge port_b_clock) disable iff (!arst_n)
    $fell(port_b_input_ready) |-> s_b_full_low) else $error("port B full without almost full");
  a_empty_low_b: assert property (@(posedge port_b_clock) disable iff (!arst_n)
    $fell(port_b_output_ready) |-> ##[0:3] !port_b_almost_empty_flag_n) else $error("port B empty flag high");
  a_full_cause_b: assert property (@(posedge port_b_clock) disable iff (!arst_n)
    $fell(port_b_almost_full_flag_n) |-> $past(b_wr, 1) || $past(b_wr, 2) || $past(b_wr, 3) || $past(b_wr, 4))
    else $error("port B almost full fell unwritten");
  a_half_zero_b: assert property (@(posedge port_b_clock) disable iff (!arst_n)
    bus_width_match_select && !port_b_size_select |-> port_b_data_bus_out[35:18] == 18'h0)
    else $error("port B half piece has upper bits set");
endmodule : bfc_port_flags_sva

// ===== sim/bfc_b_host.sv
/*
  Host model on port B of the queue block: it writes queued pieces and reads pieces.
  Assumes it runs on the port B clock and that the bench fills wq and empties seen.
*/
`include "bfc_defines.svh"
module bfc_b_host (
  input wire logic clk,
  input wire logic fall_through,
  input wire logic rd_on,
  input wire logic slow,
  output logic gate,
  output logic write_sel,
  output logic [`BFC_DATA_W-1:0] data_in,
  input wire logic [`BFC_DATA_W-1:0] data_out,
  input wire logic input_ready,
  input wire logic output_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [`BFC_DATA_W-1:0] wq[$];
  logic [`BFC_DATA_W-1:0] seen[$];
  logic pend = 1'b0;
  logic tick = 1'b0;
  initial begin
    gate = 1'b0;
    write_sel = 1'b0;
    data_in = '0;
  end
  // A write holds until the edge that takes it; a standard read shows its piece one edge later.
  always @(posedge clk) begin
    if (pend) seen.push_back(data_out);
    pend = gate && !write_sel && output_ready && !fall_through;
    if (gate && !write_sel && output_ready && fall_through) seen.push_back(data_out);
    if (gate && write_sel && input_ready) void'(wq.pop_front());
    tick = !tick;
    #1;
    write_sel = wq.size() != 0;
    gate = write_sel || (rd_on && !(slow && tick));
    // An idle bus inverts every bit each edge, so the last piece comes back every other edge.
    data_in = write_sel ? wq[0] : ~data_in;
  end
endmodule : bfc_b_host

// ===== sim/bfc_port_flags_tb.sv
/*
  Self-checking bench of the queue block with a port B host model.
  Assumes the design, the checker and the host model are compiled before it.
*/
`include "bfc_defines.svh"
module bfc_port_flags_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int W = `BFC_DATA_W;
  logic clk_sys = 1'b0;
  logic port_b_clock = 1'b0;
  logic arst_n = 1'b0;
  logic sel = 1'b1;
  logic match = 1'b0;
  logic size = 1'b0;
  logic a_gate = 1'b0;
  logic a_ws = 1'b0;
  logic [W-1:0] a_din = '0;
  logic rd_on = 1'b0;
  logic slow = 1'b0;
  logic [W-1:0] a_dout, b_din, b_dout;
  logic a_oe, a_ir, a_or, a_ae_n, a_af_n, b_gate, b_ws, b_oe, b_ir, b_or, b_ae_n, b_af_n;
  int n_fail = 0;
  int checked = 0;
  always #20 clk_sys = !clk_sys;
  always #3 port_b_clock = !port_b_clock;
  bfc_port_flags DUT (.clk_sys(clk_sys), .arst_n(arst_n), .port_b_clock(port_b_clock),
    .endian_timing_select(sel), .bus_width_match_select(match), .port_b_size_select(size),
    .a_side_empty_threshold(4'h1), .a_side_full_threshold(4'h2), .b_side_empty_threshold(4'h2),
    .b_side_full_threshold(4'h1), .port_a_transfer_gate(a_gate), .port_a_write_select(a_ws),
    .port_a_data_bus_in(a_din), .port_a_data_bus_out(a_dout), .port_a_data_bus_oe(a_oe),
    .port_a_input_ready(a_ir), .port_a_output_ready(a_or), .port_a_almost_empty_flag_n(a_ae_n),
    .port_a_almost_full_flag_n(a_af_n), .port_b_transfer_gate(b_gate), .port_b_write_select(b_ws),
    .port_b_data_bus_in(b_din), .port_b_data_bus_out(b_dout), .port_b_data_bus_oe(b_oe),
    .port_b_input_ready(b_ir), .port_b_output_ready(b_or), .port_b_almost_empty_flag_n(b_ae_n),
    .port_b_almost_full_flag_n(b_af_n));
  bfc_b_host host (.clk(port_b_clock), .fall_through(!sel), .rd_on(rd_on), .slow(slow), .gate(b_gate),
    .write_sel(b_ws), .data_in(b_din), .data_out(b_dout), .input_ready(b_ir), .output_ready(b_or));
  task automatic cmp(input string what, input logic [W-1:0] want, input logic [W-1:0] got);
    checked++;
    if (got !== want) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, want, got);
    end
  endtask : cmp
  task automatic cmp1(input string what, input logic want, input logic got);
    cmp(what, {35'h0, want}, {35'h0, got});
  endtask : cmp1
  task automatic close_out;
    if (n_fail == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  // Width and size change only under reset, since they are static while running.
  task automatic do_reset(input logic endian, input logic timing, input logic m, input logic s);
    arst_n = 1'b0;
    sel = endian;
    match = m;
    size = s;
    host.seen.delete();
    cyc(16);
    arst_n = 1'b1;
    cyc(6);
    sel = timing;
    cyc(8);
  endtask : do_reset
  task automatic a_xfer(input logic wr, input logic [W-1:0] d);
    int k;
    cyc(1);
    a_gate = 1'b1;
    a_ws = wr;
    a_din = d;
    k = 0;
    @(posedge clk_sys);
    while ((wr ? a_ir : a_or) !== 1'b1 && k < 50) begin
      k++;
      @(posedge clk_sys);
    end
    if (!wr && !sel) cmp("a read word", d, a_dout);
    #1;
    a_gate = 1'b0;
    a_din = ~d;
    if (!wr && sel) cmp("a read word", d, a_dout);
    if (wr && k == 50) cmp1("a write taken", 1'b1, 1'b0);
  endtask : a_xfer
  initial begin
    int n, w, p;
    logic [W-1:0] want;
    do_reset(1'b0, 1'b1, 1'b0, 1'b0);
    cmp1("a almost empty", 1'b0, a_ae_n);
    cmp1("b almost full", 1'b1, b_af_n);
    cmp1("b drive enable", 1'b1, b_oe);
    for (int i = 1; i <= 8; i++) begin
      a_xfer(1'b1, W'(36'h0A5A5A500 + i));
      cyc(8);
      cmp1("a almost full", (8 - i) > 2, a_af_n);
      cmp1("b almost empty", i > 2, b_ae_n);
    end
    cmp1("a input ready", 1'b0, a_ir);
    cmp("b idle word", '0, b_dout);
    slow = 1'b1;
    rd_on = 1'b1;
    cyc(20);
    rd_on = 1'b0;
    for (int i = 1; i <= 8; i++) cmp("b long word", W'(36'h0A5A5A500 + i), host.seen[i-1]);
    cmp1("a almost full", 1'b1, a_af_n);
    cmp1("b almost empty", 1'b0, b_ae_n);
    for (int i = 1; i <= 8; i++) begin
      host.wq.push_back(W'(36'h0C3C3C300 + i));
      cyc(8);
      cmp1("b almost full", (8 - i) > 1, b_af_n);
      cmp1("a almost empty", i > 1, a_ae_n);
    end
    cmp1("b input ready", 1'b0, b_ir);
    for (int i = 1; i <= 8; i++) a_xfer(1'b0, W'(36'h0C3C3C300 + i));
    for (int c = 0; c < 3; c++) begin
      n = (c != 0) ? 4 : 2;
      w = W / n;
      do_reset(c != 1, 1'b1, 1'b1, c != 0);
      a_xfer(1'b1, 36'h123456789);
      rd_on = 1'b1;
      cyc(10);
      rd_on = 1'b0;
      for (int k = 0; k < n; k++) begin
        p = (c != 1) ? n - 1 - k : k;
        want = (36'h123456789 >> (p * w)) & ((36'h1 << w) - 36'h1);
        cmp("b piece", want, host.seen[k]);
        host.wq.push_back(want);
      end
      cyc(10);
      a_xfer(1'b0, 36'h123456789);
    end
    do_reset(1'b0, 1'b0, 1'b0, 1'b0);
    a_xfer(1'b1, 36'h0FEEDBEEF);
    host.wq.push_back(36'h0ABCD1234);
    cyc(8);
    cmp1("b output ready", 1'b1, b_or);
    cmp("b shown word", 36'h0FEEDBEEF, b_dout);
    a_xfer(1'b0, 36'h0ABCD1234);
    rd_on = 1'b1;
    cyc(4);
    cmp("b taken word", 36'h0FEEDBEEF, host.seen[0]);
    close_out();
  end
  initial begin
    #100000;
    n_fail++;
    close_out();
  end
endmodule : bfc_port_flags_tb
bind bfc_port_flags bfc_port_flags_sva u_sva (.clk_sys(clk_sys), .arst_n(arst_n), .port_b_clock(port_b_clock),
  .endian_timing_select(endian_timing_select), .bus_width_match_select(bus_width_match_select),
  .port_b_size_select(port_b_size_select), .port_a_transfer_gate(port_a_transfer_gate),
  .port_a_write_select(port_a_write_select), .port_a_data_bus_oe(port_a_data_bus_oe),
  .port_a_input_ready(port_a_input_ready), .port_a_output_ready(port_a_output_ready),
  .port_a_almost_empty_flag_n(port_a_almost_empty_flag_n), .port_a_almost_full_flag_n(port_a_almost_full_flag_n),
  .port_b_transfer_gate(port_b_transfer_gate), .port_b_write_select(port_b_write_select),
  .port_b_data_bus_out(port_b_data_bus_out), .port_b_input_ready(port_b_input_ready),
  .port_b_output_ready(port_b_output_ready), .port_b_almost_empty_flag_n(port_b_almost_empty_flag_n),
  .port_b_almost_full_flag_n(port_b_almost_full_flag_n));
